/* File: dv/stq_qualifier_asserts.sv */
// Port checker of the trigger qualifier and its bind.
`timescale 1ns/1ps
`default_nettype none
module stq_qualifier_chk
  import stq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire stq_req_t req,
  input wire logic [31:0] rdata,
  input wire logic trig_out,
  input wire logic [15:0] thr_a_out,
  input wire logic [15:0] thr_b_out,
  input wire logic [15:0] thr_dig_out,
  input wire logic [15:0] la_thr_out,
  input wire logic irq
);
  // ==========================================================================
  // Sequences of the register writes that load thresholds
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence ttl_wr;
    req.wr && req.addr == A_THR_DIG && req.wdata[18:16] == 3'h1;
  endsequence
  sequence up_wr;
    req.wr && req.addr == A_THR_A;
  endsequence
  sequence lo_wr;
    req.wr && req.addr == A_THR_B;
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  trig_pulse_a: assert property (trig_out |=> !trig_out)
    else $error("trigger longer than one cycle");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !trig_out && !irq && rdata == 0)
    else $error("outputs active in reset");
  la_mirror_a: assert property (la_thr_out == thr_dig_out)
    else $error("analyzer threshold differs");
  rd_idle_a: assert property (!req.rd |=> rdata == 32'h0)
    else $error("read data without a read");
  unmapped_read_a: assert property (req.rd && req.addr == 8'hfc |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  ttl_preset_a: assert property (ttl_wr |=> ##1 thr_dig_out == MV_TTL)
    else $error("preset threshold not loaded");
  thr_upper_a: assert property (up_wr |=> ##1 thr_a_out == $past(req.wdata[15:0], 2))
    else $error("upper threshold not loaded");
  thr_lower_a: assert property (lo_wr |=> ##1 thr_b_out == $past(req.wdata[15:0], 2))
    else $error("lower threshold not loaded");
endmodule
bind stq_qualifier stq_qualifier_chk chk (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
  .trig_out(trig_out), .thr_a_out(thr_a_out), .thr_b_out(thr_b_out),
  .thr_dig_out(thr_dig_out), .la_thr_out(la_thr_out), .irq(irq));
`default_nettype wire

/* File: dv/stq_sut.sv */
// Model of the probed signal that turns an analog band into comparator levels.
`timescale 1ns/1ps
`default_nettype none
module stq_sut
  import stq_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] lvl, // Band 0 is below both thresholds, 1 between, 2 above both.
  output var stq_cmp_t cmp
);
  // ==========================================================================
  // Comparator levels
  // ==========================================================================
  // The levels settle just after the edge, as an unsynchronised pin would.
  always @(posedge clk)
  begin
    cmp <= #1 '{main: lvl != 2'h0, upper: lvl == 2'h2, lower: lvl != 2'h0};
  end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the trigger qualifier.
`timescale 1ns/1ps
`default_nettype none
module testbench
  import stq_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] lvl = 2'h0; // Band of the probed signal.
  stq_cmp_t cmp;
  stq_vid_t vid = '0; // Video strobes, idle until the video scenario drives them.
  stq_req_t req = '0;
  logic [31:0] ser = '0, rdata, r, t0;
  logic [31:0] seed = 32'h46;
  logic [15:0] par = '0, thr_a, thr_b, thr_dig, la_thr;
  logic [15:0] mv[8];
  logic trig, irq;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$]; // Expected read data, oldest first.
  int fails = 0, n_checks = 0, ntrig = 0;
  stq_sut sut (.clk(clk), .lvl(lvl), .cmp(cmp));
  stq_qualifier #(.TMO_MAX(32'd200)) uut (.clk(clk), .nrst(nrst), .cmp_in(cmp), .vid_in(vid),
    .ser_ev_in(ser), .par_in(par), .req(req), .rdata(rdata), .trig_out(trig),
    .thr_a_out(thr_a), .thr_b_out(thr_b), .thr_dig_out(thr_dig), .la_thr_out(la_thr), .irq(irq));
  // ==========================================================================
  // Clock, random source and shared tasks
  // ==========================================================================
  initial
  begin
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One register access; a read notes its expected data for the monitor.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      exp_q.push_back(d);
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic hold(input logic [1:0] l, input int n);
    lvl <= l;
    repeat (n) @(posedge clk);
  endtask
  task automatic ntr(input int k);
    chk(32'(ntrig) - t0, 32'(k));
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Monitor: counts trigger pulses and compares read data with the oldest note.
  always @(posedge clk)
  begin
    rd_d <= req.rd;
    if (trig === 1'b1)
      ntrig <= ntrig + 1;
    if (rd_d === 1'b1)
      chk(rdata, exp_q.pop_front());
  end
  // Watchdog against a hang.
  initial
  begin
    #200000;
    fails++;
    summarize();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    mv = '{16'h0, MV_TTL, MV_CMOS50, MV_CMOS33, MV_CMOS25, MV_ECL, MV_PECL, MV_ZERO};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    acc(0, A_TMO, 32'h1);
    acc(0, 8'hfc, 32'h0);
    acc(1, A_TMO, 32'h0);
    acc(0, A_TMO, 32'h1);
    acc(1, A_TMO, 32'hffff_ffff);
    acc(0, A_TMO, 32'd200);
    acc(1, A_TMO, 32'h6);
    acc(1, A_MASK, 32'h1);
    // Timeout: short levels must not fire, long ones of the selected level fire once each.
    for (int c = 0; c < 3; c++)
    begin
      acc(1, A_CTRL, 32'(c << 4) | 32'h3);
      hold(0, 16);
      acc(1, A_STAT, 32'hf);
      t0 = 32'(ntrig);
      hold(2, 4);
      hold(0, 4);
      hold(2, 12);
      hold(0, 16);
      ntr(c == 2 ? 2 : 1);
      acc(0, A_STAT, 32'h3);
      #1 chk({31'h0, irq}, 32'h1);
      acc(1, A_STAT, 32'h1);
      #1 chk({31'h0, irq}, 32'h0);
    end
    // Pulse polarity picks the edge.
    for (int p = 0; p < 2; p++)
    begin
      acc(1, A_CTRL, 32'(p << 6));
      hold(0, 8);
      t0 = 32'(ntrig);
      hold(2, 10);
      ntr(p);
      hold(0, 10);
      ntr(1);
    end
    // Runts of both kinds under each polarity choice.
    for (int p = 0; p < 3; p++)
    begin
      acc(1, A_CTRL, 32'(p << 8) | 32'h1);
      hold(0, 8);
      t0 = 32'(ntrig);
      hold(1, 8);
      hold(0, 8);
      ntr(p != 1);
      hold(2, 8);
      hold(1, 8);
      hold(2, 8);
      hold(0, 8);
      ntr(p == 2 ? 2 : 1);
    end
    // Every serial event of every bus kind, one event per kind disabled.
    for (int k = 0; k < 4; k++)
    begin
      r = xs() & 32'h7;
      acc(1, A_CTRL, 32'(k << 12) | 32'h5);
      acc(1, A_BUSEV, ~(32'h0101_0101 << r));
      for (int i = 0; i < 8; i++)
      begin
        t0 = 32'(ntrig);
        ser[k * 8 + i] <= 1'b1;
        hold(0, 2);
        ser <= 32'h0;
        hold(0, 8);
        ntr(i != r);
      end
    end
    // Parallel pattern: a match fires, a mismatch does not.
    r = xs();
    par <= ~r[15:0];
    acc(1, A_PATTERN, r & 32'hffff);
    acc(1, A_PMASK, 32'hffff);
    acc(1, A_CTRL, 32'h6);
    hold(0, 8);
    t0 = 32'(ntrig);
    par <= r[15:0];
    hold(0, 8);
    ntr(1);
    par <= r[15:0] ^ 16'h0100;
    hold(0, 8);
    ntr(1);
    // Rise and fall fire only when both thresholds are crossed in turn.
    acc(1, A_CTRL, 32'h2);
    t0 = 32'(ntrig);
    hold(1, 8);
    hold(2, 8);
    hold(1, 8);
    hold(0, 8);
    hold(2, 8);
    hold(0, 8);
    ntr(2);
    // Video: every line of a field, then only line two of the odd field.
    acc(1, A_CTRL, 32'h4);
    vid.odd_field <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      acc(1, A_VIDEO, m ? 32'h0000_0002 : 32'h0000_3000);
      t0 = 32'(ntrig);
      for (int i = 0; i < 4; i++)
      begin
        vid.field_start <= (i == 0);
        vid.line_start <= (i != 0);
        hold(0, 4);
        vid <= '{odd_field: 1'b1, field_start: 1'b0, line_start: 1'b0};
        hold(0, 4);
      end
      ntr(m ? 1 : 3);
    end
    // Thresholds and every logic-family preset.
    acc(1, A_THR_A, xs());
    acc(1, A_THR_B, xs());
    for (int k = 0; k < 8; k++)
    begin
      r = xs() & 32'hffff;
      mv[0] = r[15:0];
      acc(1, A_THR_DIG, 32'(k << 16) | r);
      @(posedge clk);
      chk({16'h0, thr_dig}, {16'h0, mv[k]});
      chk({16'h0, la_thr}, {16'h0, mv[k]});
    end
    summarize();
  end
endmodule
`default_nettype wire

/* File: hw/stq_pkg.sv */
// Package of constants, register map and types for the scope trigger qualifier.
package stq_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 4000; // Sample clock period in picoseconds.
  localparam int TMO_MIN_NS = 4; // Shortest programmable timeout in nanoseconds.
  localparam int TMO_MIN_CYC = (TMO_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint TMO_MAX_S = 10; // Longest programmable timeout in seconds.
  localparam longint TMO_MAX_CYC = (TMO_MAX_S * 64'd1000000000000) / CLK_PERIOD_PS;
  localparam int TMO_W = 32; // Width of the timeout count register.

  // ==========================================================================
  // Register offsets (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] A_CTRL = 8'h00; // Type, sub-modes, polarity.
  localparam logic [7:0] A_TMO = 8'h04; // Timeout length in cycles.
  localparam logic [7:0] A_VIDEO = 8'h08; // Video standard, field, line.
  localparam logic [7:0] A_BUSEV = 8'h0c; // Serial bus event selection.
  localparam logic [7:0] A_PATTERN = 8'h10; // Parallel pattern word.
  localparam logic [7:0] A_PMASK = 8'h14; // Parallel care mask.
  localparam logic [7:0] A_THR_A = 8'h18; // Upper/high threshold code.
  localparam logic [7:0] A_THR_B = 8'h1c; // Lower/low threshold code.
  localparam logic [7:0] A_THR_DIG = 8'h20; // Digital threshold: preset and user value.
  localparam logic [7:0] A_LA_THR = 8'h24; // Logic analyzer threshold (read only).
  localparam logic [7:0] A_STAT = 8'h28; // Sticky event status, write one to clear.
  localparam logic [7:0] A_MASK = 8'h2c; // Interrupt mask.
  localparam logic [7:0] A_STATE = 8'h30; // Live comparator state (read only).

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL_TYPE_LSB = 0; // Trigger type, 4 bits.
  localparam int CTRL_TMO_LSB = 4; // Timeout condition, 2 bits.
  localparam int CTRL_POL_LSB = 6; // Pulse/video polarity, 1 bit.
  localparam int CTRL_RUNT_LSB = 8; // Runt polarity, 2 bits.
  localparam int CTRL_BUS_LSB = 12; // Serial bus kind, 2 bits.
  localparam int VID_LINE_LSB = 0; // Video line number, 11 bits.
  localparam int VID_FIELD_LSB = 12; // Video field selection, 2 bits.
  localparam int VID_STD_LSB = 16; // Video standard, 3 bits.
  localparam int DIG_USER_LSB = 0; // User digital threshold, 16 bits (mV, signed).
  localparam int DIG_PRESET_LSB = 16; // Logic family preset, 3 bits.
  localparam logic [31:0] TMO_RST = 32'h0000_0001; // Timeout reset value.
  localparam int NEV = 4; // Number of interrupt event bits.
  localparam int EV_TRIG = 0; // Trigger fired.
  localparam int EV_TMO = 1; // Timeout fired.
  localparam int EV_RUNT = 2; // Runt seen.
  localparam int EV_BUS = 3; // Bus event seen.

  // ==========================================================================
  // Threshold presets in millivolts, signed 16 bits
  // ==========================================================================
  localparam logic [15:0] MV_TTL = 16'h0578; // 1.4 V.
  localparam logic [15:0] MV_CMOS50 = 16'h09c4; // 2.5 V.
  localparam logic [15:0] MV_CMOS33 = 16'h0672; // 1.65 V.
  localparam logic [15:0] MV_CMOS25 = 16'h04e2; // 1.25 V.
  localparam logic [15:0] MV_ECL = 16'hfaec; // -1.3 V.
  localparam logic [15:0] MV_PECL = 16'h0e74; // 3.7 V.
  localparam logic [15:0] MV_ZERO = 16'h0000; // 0 V.

  // ==========================================================================
  // Video line limits
  // ==========================================================================
  localparam logic [10:0] LN_NTSC_ODD = 11'h107; // 263.
  localparam logic [10:0] LN_NTSC_EVEN = 11'h106; // 262.
  localparam logic [10:0] LN_PAL_ODD = 11'h139; // 313.
  localparam logic [10:0] LN_PAL_EVEN = 11'h138; // 312.
  localparam logic [10:0] LN_1080P = 11'h465; // 1125.

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [3:0] {T_PULSE, T_RUNT, T_RISEFALL, T_TIMEOUT, T_VIDEO, T_SERIAL,
    T_PARALLEL} stq_type_t;
  typedef enum logic [1:0] {TM_HIGH, TM_LOW, TM_EITHER} stq_tmo_t;
  typedef enum logic [1:0] {RP_POS, RP_NEG, RP_EITHER} stq_runt_t;
  typedef enum logic [1:0] {BK_UART, BK_I2C, BK_CAN, BK_LIN} stq_bus_t;
  typedef enum logic [1:0] {VF_ODD, VF_EVEN, VF_ALL_FIELDS, VF_ALL_LINES} stq_field_t;
  typedef enum logic [2:0] {VS_NTSC, VS_PAL, VS_1080P} stq_std_t;
  typedef enum logic [2:0] {LP_USER, LP_TTL, LP_CMOS50, LP_CMOS33, LP_CMOS25, LP_ECL,
    LP_PECL, LP_ZERO} stq_preset_t;

  // Comparator levels from the front end.
  typedef struct packed {
    logic main; // Input above the trigger threshold.
    logic upper; // Input above the upper/high threshold.
    logic lower; // Input above the lower/low threshold.
  } stq_cmp_t;

  // Video timing strobes from the sync separator.
  typedef struct packed {
    logic odd_field; // Level: current field is odd.
    logic field_start; // Strobe: field begins.
    logic line_start; // Strobe: line begins.
  } stq_vid_t;

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr; // Byte address.
    logic [31:0] wdata; // Write data.
    logic wr; // Write strobe.
    logic rd; // Read strobe.
  } stq_req_t;

endpackage

/* File: hw/stq_qualifier.sv */
// Trigger condition qualifier: synchronises comparators and strobes, fires one-cycle triggers.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Stays-high timeout fires after programmed length
// - Stays-low timeout fires after programmed length
// - Either timeout fires on any steady level
// - Timeout programmable from 4 ns to 10 s
// - Positive qualifies falling, negative qualifies rising
// - Runt polarity: positive, negative or either
// - Odd field line limits per video standard
// - Even field limits; all fields, all lines
// - UART events: start, end, data, parity
// - I2C events: start, restart, stop, nack, matches
// - CAN events: frame, id, data, ack, stuffing
// - LIN events: sync, id, data, wake, sleep, error
// - Parallel inputs compared against programmed pattern
// - Runt uses separate upper and lower thresholds
// - Rise and fall use high and low thresholds
// - Digital threshold write mirrors logic analyzer threshold
// - Logic family preset loads fixed threshold
module stq_qualifier
  import stq_pkg::*;
#(
  parameter int PAR_W = 16, // Parallel bus width.
  parameter int SER_W = 8, // Serial decoder strobes per bus kind.
  parameter logic [31:0] TMO_MAX = 32'(TMO_MAX_CYC) // Longest timeout in cycles.
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire stq_cmp_t cmp_in,
  input wire stq_vid_t vid_in,
  input wire logic [4*SER_W-1:0] ser_ev_in,
  input wire logic [PAR_W-1:0] par_in,
  input wire stq_req_t req,
  output logic [31:0] rdata,
  output logic trig_out,
  output logic [15:0] thr_a_out,
  output logic [15:0] thr_b_out,
  output logic [15:0] thr_dig_out,
  output logic [15:0] la_thr_out,
  output logic irq
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int SYW = 6 + 4 * SER_W + PAR_W; // All asynchronous inputs together.
  logic [SYW-1:0] sy1_r; // First stage, read only by the second.
  logic [SYW-1:0] sy2_r; // Second stage, safe to use.
  wire [SYW-1:0] async_in = {cmp_in, vid_in, ser_ev_in, par_in};

  // Two flip-flops before any logic sees a pin.
  always_ff @(posedge clk)
  begin
    sy1_r <= async_in;
    sy2_r <= sy1_r;
  end

  wire stq_cmp_t cmp = sy2_r[SYW-1 -: 3];
  wire stq_vid_t vid = sy2_r[SYW-4 -: 3];
  wire [4*SER_W-1:0] ser = sy2_r[PAR_W +: 4*SER_W];
  wire [PAR_W-1:0] par = sy2_r[PAR_W-1:0];

  // Previous sampled comparator state for edge detection.
  stq_cmp_t cmp_d_r;
  logic vf_d_r; // Previous field-start level.
  logic vl_d_r; // Previous line-start level.
  logic [4*SER_W-1:0] ser_d_r; // Previous serial strobe levels.
  always_ff @(posedge clk)
  begin
    cmp_d_r <= cmp;
    vf_d_r <= vid.field_start;
    vl_d_r <= vid.line_start;
    ser_d_r <= ser;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [31:0] ctrl_r; // Control word.
  logic [31:0] tmo_r; // Timeout length in cycles.
  logic [31:0] video_r; // Video selection.
  logic [SER_W-1:0] busev_r; // Serial event enable mask, one bit per event.
  logic [PAR_W-1:0] pat_r; // Parallel pattern.
  logic [PAR_W-1:0] pmask_r; // Parallel care mask.
  logic [15:0] thr_a_r; // Upper or high threshold.
  logic [15:0] thr_b_r; // Lower or low threshold.
  logic [31:0] thr_dig_r; // Digital threshold preset and user value.
  logic [15:0] dig_eff_r; // Effective digital threshold.
  logic [15:0] la_thr_r; // Logic analyzer threshold copy.
  logic [NEV-1:0] stat_r; // Sticky events.
  logic [NEV-1:0] mask_r; // Interrupt mask.

  // Decoded fields.
  wire stq_type_t ttype = stq_type_t'(ctrl_r[CTRL_TYPE_LSB +: 4]);
  wire stq_tmo_t tcond = stq_tmo_t'(ctrl_r[CTRL_TMO_LSB +: 2]);
  wire pol_neg = ctrl_r[CTRL_POL_LSB];
  wire stq_runt_t rpol = stq_runt_t'(ctrl_r[CTRL_RUNT_LSB +: 2]);
  wire stq_bus_t bkind = stq_bus_t'(ctrl_r[CTRL_BUS_LSB +: 2]);
  wire [10:0] vline = video_r[VID_LINE_LSB +: 11];
  wire stq_field_t vfield = stq_field_t'(video_r[VID_FIELD_LSB +: 2]);
  wire stq_std_t vstd = stq_std_t'(video_r[VID_STD_LSB +: 3]);
  wire stq_preset_t preset = stq_preset_t'(thr_dig_r[DIG_PRESET_LSB +: 3]);

  // Write decodes.
  wire wr_hit_ctrl = req.wr && (req.addr == A_CTRL);
  wire wr_hit_tmo = req.wr && (req.addr == A_TMO);
  wire wr_hit_dig = req.wr && (req.addr == A_THR_DIG);

  // Clamp a requested timeout into the programmable range.
  function automatic logic [31:0] clamp_tmo(input logic [31:0] v);
    if (v < 32'(TMO_MIN_CYC))
      return 32'(TMO_MIN_CYC);
    else if (v > TMO_MAX)
      return TMO_MAX;
    return v;
  endfunction

  // Logic family preset to millivolts.
  function automatic logic [15:0] preset_mv(input stq_preset_t p, input logic [15:0] user);
    case (p)
      LP_TTL: return MV_TTL;
      LP_CMOS50: return MV_CMOS50;
      LP_CMOS33: return MV_CMOS33;
      LP_CMOS25: return MV_CMOS25;
      LP_ECL: return MV_ECL;
      LP_PECL: return MV_PECL;
      LP_ZERO: return MV_ZERO;
      default: return user;
    endcase
  endfunction

  wire [15:0] dig_nxt = preset_mv(stq_preset_t'(req.wdata[DIG_PRESET_LSB +: 3]),
    req.wdata[DIG_USER_LSB +: 16]);

  // Register writes.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_r <= 32'h0000_0000;
      tmo_r <= TMO_RST;
      video_r <= 32'h0000_0000;
      busev_r <= '0;
      pat_r <= '0;
      pmask_r <= '0;
      thr_a_r <= 16'h0000;
      thr_b_r <= 16'h0000;
      thr_dig_r <= 32'h0000_0000;
      dig_eff_r <= 16'h0000;
      la_thr_r <= 16'h0000;
      mask_r <= '0;
    end
    else if (req.wr)
    begin
      if (wr_hit_ctrl)
        ctrl_r <= req.wdata;
      if (wr_hit_tmo)
        tmo_r <= clamp_tmo(req.wdata);
      if (req.addr == A_VIDEO)
        video_r <= req.wdata;
      if (req.addr == A_BUSEV)
        busev_r <= req.wdata[SER_W-1:0];
      if (req.addr == A_PATTERN)
        pat_r <= req.wdata[PAR_W-1:0];
      if (req.addr == A_PMASK)
        pmask_r <= req.wdata[PAR_W-1:0];
      if (req.addr == A_THR_A)
        thr_a_r <= req.wdata[15:0];
      if (req.addr == A_THR_B)
        thr_b_r <= req.wdata[15:0];
      if (wr_hit_dig)
      begin
        thr_dig_r <= req.wdata;
        dig_eff_r <= dig_nxt;
        la_thr_r <= dig_nxt;
      end
      if (req.addr == A_MASK)
        mask_r <= req.wdata[NEV-1:0];
    end
  end

  // ==========================================================================
  // Timeout qualifier
  // ==========================================================================
  logic [31:0] tcnt_r; // Cycles the level has held.
  logic tfired_r; // Already fired for this level.
  wire lvl_edge = cmp.main != cmp_d_r.main;
  wire cond_ok = (tcond == TM_EITHER) || (tcond == TM_HIGH && cmp.main) ||
    (tcond == TM_LOW && !cmp.main);
  // The edge cycle still holds the old level's count, so it must not fire.
  wire tmo_hit = (ttype == T_TIMEOUT) && cond_ok && !tfired_r && !lvl_edge &&
    (tcnt_r + 32'h1 >= tmo_r);

  // Count the steady level; a transition or reprogramming restarts it.
  always_ff @(posedge clk)
  begin
    if (!nrst || lvl_edge || wr_hit_ctrl || wr_hit_tmo)
    begin
      tcnt_r <= 32'h0000_0000;
      tfired_r <= 1'b0;
    end
    else
    begin
      if (tcnt_r != 32'hffff_ffff)
        tcnt_r <= tcnt_r + 32'h1;
      if (tmo_hit)
        tfired_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Pulse, runt and rise/fall qualifiers
  // ==========================================================================
  wire fall = cmp_d_r.main && !cmp.main;
  wire rise = !cmp_d_r.main && cmp.main;
  wire pol_edge = pol_neg ? rise : fall;
  wire pulse_hit = (ttype == T_PULSE) && pol_edge;

  // Runt tracking: a pulse leaving one threshold and returning without the other.
  logic up_arm_r; // Crossed lower going up, upper not reached.
  logic dn_arm_r; // Fell below upper, lower not reached.
  wire pos_runt = up_arm_r && cmp_d_r.lower && !cmp.lower;
  wire neg_runt = dn_arm_r && !cmp_d_r.upper && cmp.upper;
  wire runt_ok = (rpol == RP_POS) ? pos_runt : (rpol == RP_NEG) ? neg_runt :
    (pos_runt || neg_runt);
  wire runt_hit = (ttype == T_RUNT) && runt_ok;

  // Transition tracking for rise and fall between low and high thresholds.
  logic rise_arm_r; // Left low threshold going up.
  logic fall_arm_r; // Left high threshold going down.
  wire rf_hit = (ttype == T_RISEFALL) &&
    ((rise_arm_r && !cmp_d_r.upper && cmp.upper) ||
    (fall_arm_r && cmp_d_r.lower && !cmp.lower));

  // Arming flags for runt and rise/fall.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      up_arm_r <= 1'b0;
      dn_arm_r <= 1'b0;
      rise_arm_r <= 1'b0;
      fall_arm_r <= 1'b0;
    end
    else
    begin
      up_arm_r <= (up_arm_r || (!cmp_d_r.lower && cmp.lower)) && !cmp.upper && cmp.lower;
      dn_arm_r <= (dn_arm_r || (cmp_d_r.upper && !cmp.upper)) && cmp.lower && !cmp.upper;
      rise_arm_r <= (rise_arm_r || (!cmp_d_r.lower && cmp.lower)) && cmp.lower && !cmp.upper;
      fall_arm_r <= (fall_arm_r || (cmp_d_r.upper && !cmp.upper)) && cmp.lower && !cmp.upper;
    end
  end

  // ==========================================================================
  // Video qualifier
  // ==========================================================================
  logic [10:0] line_r; // Line within field, counting from one.
  wire fstart = vid.field_start && !vf_d_r;
  wire lstart = vid.line_start && !vl_d_r;
  wire [10:0] lim = (vstd == VS_1080P) ? LN_1080P :
    (vstd == VS_PAL) ? (vid.odd_field ? LN_PAL_ODD : LN_PAL_EVEN) :
    (vid.odd_field ? LN_NTSC_ODD : LN_NTSC_EVEN);
  wire fld_ok = (vfield == VF_ODD && vid.odd_field) || (vfield == VF_EVEN && !vid.odd_field);
  wire line_match = lstart && fld_ok && (line_r + 11'h1 == vline) && (vline <= lim);
  wire vid_sel = (vfield == VF_ALL_FIELDS) ? fstart :
    (vfield == VF_ALL_LINES) ? lstart : line_match;
  wire vid_hit = (ttype == T_VIDEO) && vid_sel && (pol_neg ? cmp.main : !cmp.main);

  // Line counter restarted by each field start.
  always_ff @(posedge clk)
  begin
    if (!nrst || fstart)
      line_r <= 11'h000;
    else if (lstart && line_r != LN_1080P)
      line_r <= line_r + 11'h1;
  end

  // ==========================================================================
  // Bus qualifiers
  // ==========================================================================
  wire [SER_W-1:0] ser_grp = ser[32'(bkind) * SER_W +: SER_W];
  wire [SER_W-1:0] ser_prev = ser_d_r[32'(bkind) * SER_W +: SER_W];
  wire ser_hit = (ttype == T_SERIAL) &&
    (|(busev_r & ser_grp & ~ser_prev));
  wire par_match = ((par ^ pat_r) & pmask_r) == '0;
  logic par_d_r; // Previous match level, so a match fires once.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      par_d_r <= 1'b0;
    else
      par_d_r <= par_match;
  end
  wire par_hit = (ttype == T_PARALLEL) && par_match && !par_d_r;

  // ==========================================================================
  // Trigger output, status and read-back
  // ==========================================================================
  wire any_hit = tmo_hit || pulse_hit || runt_hit || rf_hit || vid_hit || ser_hit || par_hit;
  wire [NEV-1:0] ev = {ser_hit || par_hit, runt_hit, tmo_hit, any_hit};
  wire [NEV-1:0] clr = (req.wr && req.addr == A_STAT) ? req.wdata[NEV-1:0] : '0;
  wire [31:0] rd_mux =
    (req.addr == A_CTRL) ? ctrl_r :
    (req.addr == A_TMO) ? tmo_r :
    (req.addr == A_VIDEO) ? video_r :
    (req.addr == A_BUSEV) ? 32'(busev_r) :
    (req.addr == A_PATTERN) ? 32'(pat_r) :
    (req.addr == A_PMASK) ? 32'(pmask_r) :
    (req.addr == A_THR_A) ? {16'h0000, thr_a_r} :
    (req.addr == A_THR_B) ? {16'h0000, thr_b_r} :
    (req.addr == A_THR_DIG) ? thr_dig_r :
    (req.addr == A_LA_THR) ? {16'h0000, la_thr_r} :
    (req.addr == A_STAT) ? 32'(stat_r) :
    (req.addr == A_MASK) ? 32'(mask_r) :
    (req.addr == A_STATE) ? {29'h0, cmp} : 32'h0000_0000;

  // Outputs straight from flip-flops; events win over a same-cycle clear.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      trig_out <= 1'b0;
      stat_r <= '0;
      irq <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      trig_out <= any_hit;
      stat_r <= (stat_r & ~clr) | ev;
      irq <= |(((stat_r & ~clr) | ev) & mask_r);
      rdata <= req.rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Threshold outputs to the comparator DACs.
  always_ff @(posedge clk)
  begin
    thr_a_out <= thr_a_r;
    thr_b_out <= thr_b_r;
    thr_dig_out <= dig_eff_r;
    la_thr_out <= la_thr_r;
  end

endmodule
`default_nettype wire
